/* File: rtl/dsrc_consts.vh */
// Constants for the deep sleep retention control register block.
// Behaviour
// - Register at offset 10h, reset 0011h.
// - Bits 15-6 and 3-1 read zero.
// - Mode bit 0 means hardware runs switch.
// - Mode bit 1 means software runs switch.
// - Automatic mode: connect bit shows switch, ignores writes.
// - Manual mode: connect bit written, 1 connects.
// - Connect bit resets to one, switch connected.
// - Disconnected domain clocked no faster than 40 kHz.
// - Lock set holds pin and retention configuration.
// - Lock cleared only by software; power cycle sets it.
// - Lock reset only by supervisor or brownout reset.
// - Lock zero unlocks and restores configuration defaults.
`ifndef DSRC_CONSTS_VH
`define DSRC_CONSTS_VH
`define DSRC_CTRL_ADDR 8'h10
`define DSRC_CTRL_RESET 16'h0011
`define DSRC_CTRL_MASK 16'h0031
`define DSRC_MODE_BIT 5
`define DSRC_CONNECT_BIT 4
`define DSRC_LOCK_BIT 0
`define DSRC_SLOW_CLK_HZ 40000
`define DSRC_SYS_CLK_HZ 125000000
`define DSRC_SLOW_DIV ((`DSRC_SYS_CLK_HZ + `DSRC_SLOW_CLK_HZ - 1) / `DSRC_SLOW_CLK_HZ)
`define DSRC_SLOW_DIV_W 12
`endif

/* File: rtl/dsrc_sync2.v */
// Two-flop synchroniser for a level from outside the clock domain.
`timescale 1ns/1ps
module dsrc_sync2 (
   input wire clk_i,
   input wire rst_i,
   input wire d_i,
   output wire q_o
);
   reg meta_ff;
   reg sync_ff;
   always @(posedge clk_i) begin
      if (rst_i) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
      end else begin
         meta_ff <= d_i;
         sync_ff <= meta_ff;
      end
   end
   assign q_o = sync_ff;
endmodule

/* File: rtl/dsrc_slow_tick.v */
// Divider that gives a one-cycle tick no faster than the slow domain limit.
`timescale 1ns/1ps
`include "dsrc_consts.vh"
module dsrc_slow_tick (
   input wire clk_i,
   input wire rst_i,
   output wire tick_o
);
   localparam integer LAST_I = `DSRC_SLOW_DIV - 1;
   localparam [11:0] LAST = LAST_I[11:0];
   reg [11:0] cnt_ff;
   always @(posedge clk_i) begin
      if (rst_i || cnt_ff == LAST) begin
         cnt_ff <= 12'h000;
      end else begin
         cnt_ff <= cnt_ff + 12'h001;
      end
   end
   assign tick_o = (cnt_ff == LAST);
endmodule

/* File: rtl/dsrc_top.v */
// Deep sleep retention control register with Wishbone slave.
`timescale 1ns/1ps
`include "dsrc_consts.vh"
module dsrc_top (
   input wire clk_i,
   input wire rst_i,
   input wire por_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [1:0] wb_sel_i,
   input wire [15:0] wb_dat_i,
   output reg [15:0] wb_dat_o,
   output reg wb_ack_o,
   output wire wb_err_o,
   input wire auto_switch_req_i,
   output wire switch_connect_o,
   output wire config_lock_o,
   output wire config_defaults_o,
   output wire domain_clk_en_o
);
   // The power-cycle reset arrives from the supply monitor, asynchronously.
   wire por_sync;
   wire auto_req_sync;
   wire slow_tick;
   reg mode_ff;
   reg connect_ff;
   reg lock_ff;
   reg auto_sw_ff;
   reg nxt_mode;
   reg nxt_connect;
   reg nxt_lock;
   reg nxt_auto_sw;
   wire req;
   wire hit;
   wire wr;
   wire lo_en;

   dsrc_sync2 u_por_sync (
      .clk_i(clk_i),
      .rst_i(1'b0),
      .d_i(por_i),
      .q_o(por_sync)
   );

   // Left out of the system reset so the live request is not masked after reset.
   dsrc_sync2 u_req_sync (
      .clk_i(clk_i),
      .rst_i(1'b0),
      .d_i(auto_switch_req_i),
      .q_o(auto_req_sync)
   );

   dsrc_slow_tick u_tick (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_o(slow_tick)
   );

   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign hit = (wb_adr_i == `DSRC_CTRL_ADDR);
   // A write lands at the edge where the master sees the acknowledge.
   assign wr = wb_cyc_i && wb_stb_i && wb_ack_o && hit && wb_we_i;
   assign lo_en = wb_sel_i[0];
   assign wb_err_o = 1'b0;

   always @* begin
      nxt_mode = mode_ff;
      nxt_connect = connect_ff;
      nxt_lock = lock_ff;
      nxt_auto_sw = auto_req_sync;
      // Only bits 5, 4 and 0 are stored; the rest of the write is dropped.
      if (wr && lo_en) begin
         nxt_mode = wb_dat_i[`DSRC_MODE_BIT];
         if (wb_dat_i[`DSRC_MODE_BIT]) begin
            nxt_connect = wb_dat_i[`DSRC_CONNECT_BIT];
         end
         nxt_lock = wb_dat_i[`DSRC_LOCK_BIT];
      end
   end

   // Mode and connect follow the system reset; the lock only the power cycle.
   always @(posedge clk_i) begin
      if (rst_i) begin
         mode_ff <= 1'b0;
         connect_ff <= 1'b1;
         auto_sw_ff <= 1'b1;
      end else begin
         mode_ff <= nxt_mode;
         connect_ff <= nxt_connect;
         auto_sw_ff <= nxt_auto_sw;
      end
   end

   always @(posedge clk_i) begin
      if (por_sync) begin
         lock_ff <= 1'b1;
      end else begin
         lock_ff <= nxt_lock;
      end
   end

   // In automatic mode the switch is the hardware request, kept connected at reset.
   assign switch_connect_o = mode_ff ? connect_ff : auto_sw_ff;
   assign config_lock_o = lock_ff;
   assign config_defaults_o = !lock_ff;
   assign domain_clk_en_o = switch_connect_o ? 1'b1 : slow_tick;

   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 16'h0000;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= 16'h0000;
         if (req && !wb_we_i && hit) begin
            // Automatic mode reads back the live switch state.
            wb_dat_o <= {10'h000, mode_ff, switch_connect_o, 3'h0, lock_ff};
         end
      end
   end
endmodule

/* File: test/dsrc_props.sv */
// Checker for the retention control register block.
`timescale 1ns/1ps
module dsrc_props (
   input wire clk_i,
   input wire rst_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [15:0] wb_dat_o,
   input wire wb_ack_o,
   input wire switch_connect_o,
   input wire config_lock_o,
   input wire config_defaults_o,
   input wire domain_clk_en_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack");
   ack_take_a: assert property (wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("take");
   rsvd_zero_a: assert property (wb_ack_o |-> !(wb_dat_o & 16'hFFCE)) else $error("rsvd");
   read_state_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h10 |->
      wb_dat_o[4] == switch_connect_o && wb_dat_o[0] == config_lock_o) else $error("state");
   lock_fall_a: assert property ($fell(config_lock_o) |-> $past(wb_ack_o && wb_we_i))
      else $error("lock");
   dflt_inv_a: assert property (config_defaults_o != config_lock_o) else $error("dflt");
   conn_clk_a: assert property (switch_connect_o |-> domain_clk_en_o) else $error("clk");
   slow_tick_a: assert property (domain_clk_en_o && !switch_connect_o ##1
      !switch_connect_o |-> !domain_clk_en_o) else $error("tick");
endmodule
bind dsrc_top dsrc_props p (.*);

/* File: test/tb_deep_sleep_retention_control.sv */
// Testbench for the retention control register block.
`timescale 1ns/1ps
module tb_deep_sleep_retention_control;
   reg clk_i = 0, rst_i = 1, por = 1, cyc = 0, stb = 0, we = 0, asw = 1;
   reg [7:0] adr = 8'h00;
   reg [15:0] dat = 16'h0000, rdv;
   integer n_mismatch = 0, n_checks = 0, t = 0, nce = 0;
   wire [15:0] dq;
   wire ack, sw, lk, df, ce;
   dsrc_top uut (.clk_i(clk_i), .rst_i(rst_i), .por_i(por), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(2'h3), .wb_dat_i(dat), .wb_dat_o(dq),
      .wb_ack_o(ack), .wb_err_o(), .auto_switch_req_i(asw), .switch_connect_o(sw),
      .config_lock_o(lk), .config_defaults_o(df), .domain_clk_en_o(ce));
   task tally_and_finish; begin
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   end endtask
   task chk(input [15:0] g, input [15:0] e); begin
      n_checks = n_checks + 1;
      if (g !== e) begin
         n_mismatch = n_mismatch + 1;
         $display("FAIL %0t got %h exp %h", $time, g, e);
      end
   end endtask
   task acc(input w, input [7:0] a, input [15:0] d); begin
      @(posedge clk_i);
      {cyc, stb, we, adr, dat} <= {2'h3, w, a, d};
      @(posedge clk_i);
      while (ack !== 1'b1) @(posedge clk_i);
      rdv = dq;
      {cyc, stb, we} <= 3'h0;
   end endtask
   task rd(input [7:0] a, input [15:0] e); begin
      acc(1'b0, a, 16'h0000);
      chk(rdv, e);
   end endtask
   initial forever #4 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      t = t + 1;
      if (t == 20000) begin
         n_mismatch = n_mismatch + 1;
         tally_and_finish;
      end
   end
   initial begin
      repeat (10) @(posedge clk_i);
      {rst_i, por} <= 2'h0;
      rd(8'h10, 16'h0011);
      $display("reset test done");
      acc(1'b1, 8'h10, 16'hFFFF);
      rd(8'h10, 16'h0031);
      acc(1'b1, 8'h10, 16'hFFE1);
      rd(8'h10, 16'h0021);
      chk(sw, 1'b0);
      repeat (6250) begin
         @(posedge clk_i);
         nce = nce + ce;
      end
      chk(nce, 16'h0002);
      $display("manual test done");
      asw <= 1'b0;
      acc(1'b1, 8'h10, 16'h0010);
      rd(8'h10, 16'h0000);
      chk(df, 1'b1);
      asw <= 1'b1;
      repeat (4) @(posedge clk_i);
      rd(8'h10, 16'h0010);
      acc(1'b1, 8'h12, 16'hFFFF);
      rd(8'h12, 16'h0000);
      rd(8'h10, 16'h0010);
      $display("auto test done");
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(8'h10, 16'h0010);
      por <= 1'b1;
      repeat (4) @(posedge clk_i);
      por <= 1'b0;
      rd(8'h10, 16'h0011);
      $display("power test done");
      tally_and_finish;
   end
endmodule
